// file: ecse_capture.sv
// event capture status flags, capture enables and global summary
`timescale 1ns/1ps
module ecse_capture #(
    parameter bit HAS_SENSOR_SUPPLY = 1'b1,
    parameter int SILENCE_CYCLES = ecse_pkg::SILENCE_TIMEOUT_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // register port from the serial front end
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // detector levels from analog blocks
    input wire logic mcu_supply_under,
    input wire logic sensor_supply_under,
    input wire logic sensor_supply_over,
    input wire logic tx_clamped,
    input wire logic can_wake_detect,
    input wire logic can_offline,
    input wire logic partial_net_frame_error,
    input wire logic bus_activity,
    input wire logic wake_pin,
    input wire logic overtemp_warn,
    // same-clock event pulses
    input wire logic serial_failure,
    input wire logic watchdog_failure,
    // any event pending
    output logic event_pending
);
    import ecse_pkg::*;

    logic [NUM_SYNC-1:0] raw_in;
    logic [NUM_SYNC-1:0] sync_a;
    logic [NUM_SYNC-1:0] sync_b;
    logic [NUM_SYNC-1:0] sync_c;
    logic [7:0] sys_en;
    logic [7:0] sup_en;
    logic [7:0] trx_en;
    logic [7:0] wake_en;
    logic [7:0] sys_flags;
    logic [7:0] sup_flags;
    logic [7:0] trx_flags;
    logic [7:0] wake_flags;
    logic [SILENCE_CNT_W-1:0] silence_cnt;
    logic silence_hit;

    assign raw_in = {overtemp_warn, wake_pin, bus_activity, partial_net_frame_error,
                     can_offline, can_wake_detect, tx_clamped, sensor_supply_over,
                     sensor_supply_under, mcu_supply_under};

    // two-flop synchronisers plus a third stage for edge detection
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SYNC; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                    sync_c[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_c[gi] <= sync_b[gi];
                end
            end
        end
    endgenerate

    wire [NUM_SYNC-1:0] rise = sync_b & ~sync_c;
    wire [NUM_SYNC-1:0] fall = ~sync_b & sync_c;

    // bus silence timer, restarted by any activity
    localparam logic [SILENCE_CNT_W-1:0] SILENCE_LAST = SILENCE_CNT_W'(SILENCE_CYCLES - 1);
    wire silence_reached = silence_cnt == SILENCE_LAST;
    wire [SILENCE_CNT_W-1:0] next_silence_cnt =
        sync_b[SYNC_BUS_ACT] ? '0 :
        silence_reached ? silence_cnt : silence_cnt + 1'b1;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            silence_cnt <= '0;
        end else begin
            silence_cnt <= next_silence_cnt;
        end
    end

    // count holds at its end, so one pulse per silent stretch
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            silence_hit <= 1'b0;
        end else begin
            silence_hit <= silence_reached;
        end
    end
    wire silence_event = silence_reached & ~silence_hit & ~sync_b[SYNC_BUS_ACT];

    // address decode
    wire wr_sys_en = reg_wr && reg_addr == ADDR_SYS_EN;
    wire wr_sup_en = reg_wr && reg_addr == ADDR_SUP_EN;
    wire wr_trx_en = reg_wr && reg_addr == ADDR_TRX_EN;
    wire wr_wake_en = reg_wr && reg_addr == ADDR_WAKE_EN;
    wire wr_sys_flags = reg_wr && reg_addr == ADDR_SYS_FLAGS;
    wire wr_sup_flags = reg_wr && reg_addr == ADDR_SUP_FLAGS;
    wire wr_trx_flags = reg_wr && reg_addr == ADDR_TRX_FLAGS;
    wire wr_wake_flags = reg_wr && reg_addr == ADDR_WAKE_FLAGS;

    wire [7:0] sup_mask = HAS_SENSOR_SUPPLY ? SUP_EN_MASK_FULL : SUP_EN_MASK_BASIC;

    // events per group, raw except the enable-gated serial failure and overtemp events
    logic [7:0] sys_ev;
    logic [7:0] sup_ev;
    logic [7:0] trx_ev;
    logic [7:0] wake_ev;
    always_comb begin
        sys_ev = 8'h00;
        sys_ev[SYS_WDF_BIT] = watchdog_failure;
        sys_ev[SYS_SPIF_BIT] = serial_failure & sys_en[SYS_SPIF_BIT];
        sys_ev[SYS_OTW_BIT] = rise[SYNC_OTW] & sys_en[SYS_OTW_BIT];
    end

    always_comb begin
        sup_ev = 8'h00;
        sup_ev[SUP_MCU_UNDER_BIT] = rise[SYNC_MCU_UNDER];
        sup_ev[SUP_SENS_UNDER_BIT] = rise[SYNC_SENS_UNDER];
        sup_ev[SUP_SENS_OVER_BIT] = rise[SYNC_SENS_OVER];
    end

    always_comb begin
        trx_ev = 8'h00;
        trx_ev[TRX_PN_ERR_BIT] = rise[SYNC_PN_ERR];
        trx_ev[TRX_SILENCE_BIT] = silence_event;
        trx_ev[TRX_FAIL_BIT] = (sync_b[SYNC_MCU_UNDER] | sync_b[SYNC_TX_CLAMP])
                               & ~(sync_c[SYNC_MCU_UNDER] | sync_c[SYNC_TX_CLAMP]);
        trx_ev[TRX_WAKE_BIT] = rise[SYNC_CAN_WAKE] & sync_b[SYNC_OFFLINE];
    end

    always_comb begin
        wake_ev = 8'h00;
        wake_ev[WAKE_RISE_BIT] = rise[SYNC_WAKE_PIN];
        wake_ev[WAKE_FALL_BIT] = fall[SYNC_WAKE_PIN];
    end

    // gating by enables; frame error and watchdog failure always captured
    wire [7:0] trx_gate = trx_en | (8'h01 << TRX_PN_ERR_BIT);
    wire [7:0] sup_set = sup_ev & sup_en & sup_mask;
    wire [7:0] trx_set = trx_ev & trx_gate & TRX_FLAG_MASK;
    wire [7:0] wake_set = wake_ev & wake_en & WAKE_EN_MASK;
    wire [7:0] sys_set = sys_ev & SYS_FLAG_MASK;

    // write one clears, a coincident set wins
    wire [7:0] sys_clr = wr_sys_flags ? reg_wdata : 8'h00;
    wire [7:0] sup_clr = wr_sup_flags ? reg_wdata : 8'h00;
    wire [7:0] trx_clr = wr_trx_flags ? reg_wdata : 8'h00;
    wire [7:0] wake_clr = wr_wake_flags ? reg_wdata : 8'h00;
    wire [7:0] next_sys_flags = (sys_flags & ~sys_clr) | sys_set;
    wire [7:0] next_sup_flags = (sup_flags & ~sup_clr) | sup_set;
    wire [7:0] next_trx_flags = (trx_flags & ~trx_clr) | trx_set;
    wire [7:0] next_wake_flags = (wake_flags & ~wake_clr) | wake_set;

    // enable registers, reserved bits masked
    wire [7:0] next_sys_en = wr_sys_en ? reg_wdata & SYS_EN_MASK : sys_en;
    wire [7:0] next_sup_en = wr_sup_en ? reg_wdata & sup_mask : sup_en;
    wire [7:0] next_trx_en = wr_trx_en ? reg_wdata & TRX_EN_MASK : trx_en;
    wire [7:0] next_wake_en = wr_wake_en ? reg_wdata & WAKE_EN_MASK : wake_en;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sys_en <= EN_RESET;
        end else begin
            sys_en <= next_sys_en;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sup_en <= EN_RESET;
        end else begin
            sup_en <= next_sup_en;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            trx_en <= EN_RESET;
        end else begin
            trx_en <= next_trx_en;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wake_en <= EN_RESET;
        end else begin
            wake_en <= next_wake_en;
        end
    end

    // power-on flag comes up set after reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sys_flags <= SYS_FLAGS_RESET;
        end else begin
            sys_flags <= next_sys_flags;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sup_flags <= FLAGS_RESET;
        end else begin
            sup_flags <= next_sup_flags;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            trx_flags <= FLAGS_RESET;
        end else begin
            trx_flags <= next_trx_flags;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wake_flags <= FLAGS_RESET;
        end else begin
            wake_flags <= next_wake_flags;
        end
    end

    // global summary
    wire sys_pending = |sys_flags;
    wire sup_pending = |sup_flags;
    wire trx_pending = |trx_flags;
    wire wake_pending = |wake_flags;
    wire [7:0] global_status = {4'h0, wake_pending, trx_pending, sup_pending, sys_pending};
    wire next_event_pending = |global_status;

    // read select per address, unmapped reads zero
    wire sel_sys_en = reg_addr == ADDR_SYS_EN;
    wire sel_sup_en = reg_addr == ADDR_SUP_EN;
    wire sel_trx_en = reg_addr == ADDR_TRX_EN;
    wire sel_wake_en = reg_addr == ADDR_WAKE_EN;
    wire sel_global = reg_addr == ADDR_GLOBAL;
    wire sel_sys_flags = reg_addr == ADDR_SYS_FLAGS;
    wire sel_sup_flags = reg_addr == ADDR_SUP_FLAGS;
    wire sel_trx_flags = reg_addr == ADDR_TRX_FLAGS;
    wire sel_wake_flags = reg_addr == ADDR_WAKE_FLAGS;
    wire [7:0] rd_mux = ({8{sel_sys_en}} & sys_en)
        | ({8{sel_sup_en}} & sup_en)
        | ({8{sel_trx_en}} & trx_en)
        | ({8{sel_wake_en}} & wake_en)
        | ({8{sel_global}} & global_status)
        | ({8{sel_sys_flags}} & sys_flags)
        | ({8{sel_sup_flags}} & sup_flags)
        | ({8{sel_trx_flags}} & trx_flags)
        | ({8{sel_wake_flags}} & wake_flags);

    wire [7:0] next_rdata = reg_rd ? rd_mux : reg_rdata;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            event_pending <= 1'b0;
        end else begin
            event_pending <= next_event_pending;
        end
    end
endmodule

// file: ecse_pkg.sv
// constants for the event capture status and enable register bank
package ecse_pkg;
    localparam logic [6:0] ADDR_SYS_EN = 7'h04;
    localparam logic [6:0] ADDR_SUP_EN = 7'h1C;
    localparam logic [6:0] ADDR_TRX_EN = 7'h23;
    localparam logic [6:0] ADDR_WAKE_EN = 7'h4C;
    localparam logic [6:0] ADDR_GLOBAL = 7'h60;
    localparam logic [6:0] ADDR_SYS_FLAGS = 7'h61;
    localparam logic [6:0] ADDR_SUP_FLAGS = 7'h62;
    localparam logic [6:0] ADDR_TRX_FLAGS = 7'h63;
    localparam logic [6:0] ADDR_WAKE_FLAGS = 7'h64;
    // writable bit masks, reserved bits read zero
    localparam logic [7:0] SYS_EN_MASK = 8'h06;
    localparam logic [7:0] SUP_EN_MASK_FULL = 8'h07;
    localparam logic [7:0] SUP_EN_MASK_BASIC = 8'h01;
    localparam logic [7:0] TRX_EN_MASK = 8'h13;
    localparam logic [7:0] WAKE_EN_MASK = 8'h03;
    localparam logic [7:0] SYS_FLAG_MASK = 8'h17;
    localparam logic [7:0] TRX_FLAG_MASK = 8'h33;
    // field positions
    localparam int SYS_WDF_BIT = 0;
    localparam int SYS_SPIF_BIT = 1;
    localparam int SYS_OTW_BIT = 2;
    localparam int SYS_PO_BIT = 4;
    localparam int SUP_MCU_UNDER_BIT = 0;
    localparam int SUP_SENS_UNDER_BIT = 1;
    localparam int SUP_SENS_OVER_BIT = 2;
    localparam int TRX_WAKE_BIT = 0;
    localparam int TRX_FAIL_BIT = 1;
    localparam int TRX_SILENCE_BIT = 4;
    localparam int TRX_PN_ERR_BIT = 5;
    localparam int WAKE_FALL_BIT = 0;
    localparam int WAKE_RISE_BIT = 1;
    // values after reset
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] SYS_FLAGS_RESET = 8'h10;
    // synchronised detector inputs
    localparam int NUM_SYNC = 10;
    localparam int SYNC_MCU_UNDER = 0;
    localparam int SYNC_SENS_UNDER = 1;
    localparam int SYNC_SENS_OVER = 2;
    localparam int SYNC_TX_CLAMP = 3;
    localparam int SYNC_CAN_WAKE = 4;
    localparam int SYNC_OFFLINE = 5;
    localparam int SYNC_PN_ERR = 6;
    localparam int SYNC_BUS_ACT = 7;
    localparam int SYNC_WAKE_PIN = 8;
    localparam int SYNC_OTW = 9;
    // bus silence timing
    localparam int CLK_MHZ = 40;
    localparam int SILENCE_TIMEOUT_US = 1000;
    localparam int SILENCE_TIMEOUT_CYCLES = SILENCE_TIMEOUT_US * CLK_MHZ;
    localparam int SILENCE_CNT_W = 24;
endpackage

// file: ecse_capture_asserts.sv
// assertion checker for the event capture register bank
`timescale 1ns/1ps
module ecse_capture_chk
    import ecse_pkg::*;
#(
    parameter bit HAS_SENSOR_SUPPLY = 1'b1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // register port
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic event_pending
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_rd(logic [6:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_wr_rd(logic [6:0] a);
        reg_wr && !reg_rd && reg_addr == a ##1 !reg_wr ##1 reg_rd && reg_addr == a;
    endsequence
    property p_sup_rsv;
        s_rd(ADDR_SUP_FLAGS) |=> reg_rvalid && reg_rdata[7:3] == 5'h00;
    endproperty
    property p_trx_rsv;
        s_rd(ADDR_TRX_FLAGS) |=> (reg_rdata & 8'hCC) == 8'h00;
    endproperty
    property p_wake_rsv;
        s_rd(ADDR_WAKE_FLAGS) |=> reg_rdata[7:2] == 6'h00;
    endproperty
    property p_sys_en;
        s_rd(ADDR_SYS_EN) |=> (reg_rdata & 8'hF9) == 8'h00;
    endproperty
    property p_trx_en;
        s_rd(ADDR_TRX_EN) |=> (reg_rdata & 8'hEC) == 8'h00;
    endproperty
    property p_glob;
        s_rd(ADDR_GLOBAL) |=> reg_rvalid && reg_rdata[7:4] == 4'h0;
    endproperty
    property p_wake_en;
        s_wr_rd(ADDR_WAKE_EN) |=> reg_rdata == ($past(reg_wdata, 3) & 8'h03);
    endproperty
    property p_sup_en;
        s_wr_rd(ADDR_SUP_EN) |=>
            reg_rdata == ($past(reg_wdata, 3) & (HAS_SENSOR_SUPPLY ? 8'h07 : 8'h01));
    endproperty
    property p_po;
        $fell(srst) |=> event_pending;
    endproperty
    a_sup_rsv: assert property (p_sup_rsv) else $error("supply flags reserved bits set");
    a_trx_rsv: assert property (p_trx_rsv) else $error("transceiver flags reserved bits");
    a_wake_rsv: assert property (p_wake_rsv) else $error("wake flags reserved bits set");
    a_sys_en: assert property (p_sys_en) else $error("system enable reserved bits set");
    a_trx_en: assert property (p_trx_en) else $error("transceiver enable reserved bits");
    a_glob: assert property (p_glob) else $error("summary reserved bits set");
    a_wake_en: assert property (p_wake_en) else $error("wake enable readback wrong");
    a_sup_en: assert property (p_sup_en) else $error("supply enable readback wrong");
    a_po: assert property (p_po) else $error("no pending event after reset");
endmodule
bind ecse_capture ecse_capture_chk #(.HAS_SENSOR_SUPPLY(HAS_SENSOR_SUPPLY)) u_chk (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .event_pending(event_pending));

// file: ecse_host.sv
// host model driving the register port of the event capture bank
`timescale 1ns/1ps
module ecse_host (
    // clock
    input wire logic sys_clk,
    // register port
    output logic [6:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 7'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
        v = reg_rvalid;
    endtask
    // clear only what the last read showed set
    task automatic clear_seen(input logic [6:0] a);
        logic [7:0] d;
        logic v;
        rd(a, d, v);
        wr(a, d);
    endtask
endmodule

// file: testbench.sv
// self-checking testbench for the event capture register bank
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    import ecse_pkg::*;
    localparam logic [6:0] EN_A [4] = '{7'h04, 7'h1C, 7'h23, 7'h4C};
    localparam logic [7:0] EN_M [4] = '{8'h06, 8'h07, 8'h13, 8'h03};
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [9:0] det = 10'h080;
    logic ser_fail = 1'b0;
    logic wdog_fail = 1'b0;
    logic [6:0] reg_addr;
    logic reg_wr, reg_rd, reg_rvalid, event_pending;
    logic [7:0] reg_wdata, reg_rdata;
    logic [7:0] basic_rdata;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    ecse_capture #(.HAS_SENSOR_SUPPLY(1'b1), .SILENCE_CYCLES(8)) dut (.sys_clk(sys_clk),
        .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .mcu_supply_under(det[0]), .sensor_supply_under(det[1]), .sensor_supply_over(det[2]),
        .tx_clamped(det[3]), .can_wake_detect(det[4]), .can_offline(det[5]),
        .partial_net_frame_error(det[6]), .bus_activity(det[7]), .wake_pin(det[8]),
        .overtemp_warn(det[9]), .serial_failure(ser_fail), .watchdog_failure(wdog_fail),
        .event_pending(event_pending));
    ecse_capture #(.HAS_SENSOR_SUPPLY(1'b0), .SILENCE_CYCLES(8)) dut_basic (.sys_clk(sys_clk),
        .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(basic_rdata), .reg_rvalid(),
        .mcu_supply_under(det[0]), .sensor_supply_under(det[1]), .sensor_supply_over(det[2]),
        .tx_clamped(det[3]), .can_wake_detect(det[4]), .can_offline(det[5]),
        .partial_net_frame_error(det[6]), .bus_activity(det[7]), .wake_pin(det[8]),
        .overtemp_warn(det[9]), .serial_failure(ser_fail), .watchdog_failure(wdog_fail),
        .event_pending());
    ecse_host u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic give_verdict();
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        u_host.rd(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, e)
    endtask
    task automatic set_det(input int i, input logic b);
        @(posedge sys_clk);
        det[i] <= b;
        repeat (5) @(posedge sys_clk);
    endtask
    // toggle every detector but the offline qualifier, then pulse the same-clock events
    task automatic flip_all();
        for (int i = 0; i < 10; i++) begin
            if (i != SYNC_OFFLINE) set_det(i, !det[i]);
        end
        @(posedge sys_clk);
        ser_fail <= 1'b1;
        wdog_fail <= 1'b1;
        @(posedge sys_clk);
        ser_fail <= 1'b0;
        wdog_fail <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        rchk(ADDR_SYS_FLAGS, 8'h10);
        rchk(ADDR_GLOBAL, 8'h01);
        rchk(7'h00, 8'h00);
        for (int i = 0; i < 4; i++) begin
            u_host.wr(EN_A[i], 8'hFF);
            rchk(EN_A[i], EN_M[i]);
            if (i == 1) `CHK(basic_rdata, 8'h01)
        end
        u_host.wr(ADDR_GLOBAL, 8'hFF);
        rchk(ADDR_GLOBAL, 8'h01);
        set_det(SYNC_OFFLINE, 1'b1);
        flip_all();
        set_det(SYNC_WAKE_PIN, 1'b0);
        rchk(ADDR_SYS_FLAGS, 8'h17);
        rchk(ADDR_SUP_FLAGS, 8'h07);
        `CHK(basic_rdata, 8'h01)
        rchk(ADDR_TRX_FLAGS, 8'h33);
        rchk(ADDR_WAKE_FLAGS, 8'h03);
        rchk(ADDR_GLOBAL, 8'h0F);
        u_host.wr(ADDR_TRX_FLAGS, 8'h01);
        rchk(ADDR_TRX_FLAGS, 8'h32);
        for (int a = 'h61; a <= 'h64; a++) begin
            u_host.clear_seen(7'(a));
            rchk(7'(a), 8'h00);
        end
        rchk(ADDR_GLOBAL, 8'h00);
        `CHK(event_pending, 1'b0)
        for (int i = 0; i < 4; i++) u_host.wr(EN_A[i], 8'h00);
        flip_all();
        flip_all();
        rchk(ADDR_SUP_FLAGS, 8'h00);
        `CHK(basic_rdata, 8'h00)
        rchk(ADDR_TRX_FLAGS, 8'h20);
        rchk(ADDR_WAKE_FLAGS, 8'h00);
        rchk(ADDR_SYS_FLAGS, 8'h01);
        give_verdict();
    end
endmodule
